// [core/dwc_pkg.sv]
// shared constants and types of the digital potentiometer wiper control
`default_nettype none

package dwc_pkg;

    // =========================================================
    // position word
    localparam int unsigned POS_W        = 10;
    localparam logic [9:0]  POS_MIN      = 10'h000;
    localparam logic [9:0]  POS_MAX      = 10'h3FF;
    // factory content of the nonvolatile register: midscale
    localparam logic [9:0]  NV_FACTORY   = 10'h200;

    // =========================================================
    // serial frame layout, bit index inside the shift word after the last clock
    localparam int unsigned SHIFT_W      = 24;
    localparam int unsigned CNT_W        = 5;
    localparam logic [4:0]  LEN_LONG     = 5'h18;
    localparam logic [4:0]  LEN_SHORT    = 5'h08;
    localparam logic [4:0]  CNT_SAT      = 5'h1F;
    localparam int unsigned LONG_CMD_HI  = 21;
    localparam int unsigned LONG_CMD_LO  = 20;
    localparam int unsigned LONG_POS_MSB = 15;
    localparam int unsigned LONG_POS_LSB = 6;
    localparam int unsigned SHORT_CMD_HI = 5;
    localparam int unsigned SHORT_CMD_LO = 4;

    // =========================================================
    // serial commands
    localparam logic [1:0]  CMD_WRITE    = 2'h0;
    localparam logic [1:0]  CMD_SAVE     = 2'h2;
    localparam logic [1:0]  CMD_RESTORE  = 2'h3;

    // =========================================================
    // timing: nonvolatile save takes at most 12 ms at 250 MHz
    localparam int unsigned CLK_FREQ_KHZ    = 250000;
    localparam int unsigned NV_SAVE_TIME_MS = 12;
    localparam int unsigned NV_SAVE_CYCLES  = NV_SAVE_TIME_MS * CLK_FREQ_KHZ;
    localparam int unsigned TIMER_W         = 22;

    // =========================================================
    // controller states
    typedef enum logic [1:0] {
        DWC_BOOT,
        DWC_IDLE,
        DWC_SAVE
    } dwc_state_t;

endpackage

`default_nettype wire

// [core/dwc_link_shift.sv]
// serial-clock side shift register and clock counter of the wiper control
`default_nettype none

module dwc_link_shift (
    // link clock and frame clear
    input  wire logic        link_clk,
    input  wire logic        clear_n,
    // pins sampled on the link clock
    input  wire logic        cs_n,
    input  wire logic        din,
    // frame contents, stable while chip select is high until the frame clear zeroes them
    output logic [23:0]      shift_word,
    output logic [4:0]       bit_count
);

    typedef struct packed {
        logic [23:0] shift;
        logic [4:0]  count;
    } dwc_link_st_t;

    dwc_link_st_t st_reg;
    dwc_link_st_t st_next;

    // =========================================================
    // next state
    always_comb begin
        st_next = st_reg;
        if (!cs_n) begin
            st_next.shift = {st_reg.shift[22:0], din};
            if (st_reg.count != dwc_pkg::CNT_SAT) begin
                st_next.count = st_reg.count + 5'h01;
            end
        end
    end

    // =========================================================
    // registers; the clear is released by the core once a frame has begun
    always_ff @(posedge link_clk or negedge clear_n) begin
        if (!clear_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign shift_word = st_reg.shift;
    assign bit_count  = st_reg.count;

endmodule

`default_nettype wire

// [core/dwc_wiper_ctrl.sv]
// wiper position controller with up/down and three-wire serial front ends
`default_nettype none

// Contract
// - strap low selects up/down stepping
// - chip select high ignores step inputs
// - falling step edge moves the counter
// - direction high adds one
// - direction low subtracts one
// - deselect with strobe high saves position
// - deselect with strobe low keeps nonvolatile
// - command 10 saves wiper to nonvolatile
// - save completes within 12 ms
// - command 11 reloads wiper from nonvolatile
// - power-up copies nonvolatile into wiper
// - nonvolatile starts at midscale
// - idle device drops into standby
// - serial bits shift on rising clock
// - write command 00, 24 clocks, MSB first
// - copy commands take 8 or 24 clocks
// - chip select rise decodes and updates
module dwc_wiper_ctrl #(
    parameter int unsigned NV_SAVE_CYCLES = dwc_pkg::NV_SAVE_CYCLES
) (
    // core clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // host pins; serial_clk is the shift clock and, in up/down mode, the step strobe
    input  wire logic        serial_clk,
    input  wire logic        cs_n,
    input  wire logic        din_dir,
    input  wire logic        iface_mode_strap,
    // wiper and nonvolatile state
    output logic [9:0]       wiper_pos,
    output logic [9:0]       nv_pos,
    // status
    output logic             nv_busy,
    output logic             standby
);

    localparam logic [21:0] SAVE_LAST = 22'(NV_SAVE_CYCLES - 1);

    typedef struct packed {
        dwc_pkg::dwc_state_t state;
        logic [9:0]          wiper;
        logic [9:0]          nv;
        logic [9:0]          pending;
        logic [21:0]         timer;
        logic                cs_s1;
        logic                cs_s2;
        logic                cs_d;
        logic                stb_s1;
        logic                stb_s2;
        logic                stb_d;
        logic                dir_s1;
        logic                dir_s2;
        logic                mode_s1;
        logic                mode_s2;
        logic                clear_n;
        logic                standby;
        logic                busy;
    } dwc_core_st_t;

    dwc_core_st_t st_reg;
    dwc_core_st_t st_next;

    logic [23:0] link_word;
    logic [4:0]  link_count;

    // =========================================================
    // saturating one-step move of a position
    function automatic logic [9:0] dwc_step(input logic [9:0] pos, input logic up);
        logic [9:0] res;
        res = pos;
        if (up) begin
            if (pos != dwc_pkg::POS_MAX) begin
                res = pos + 10'h001;
            end
        end else begin
            if (pos != dwc_pkg::POS_MIN) begin
                res = pos - 10'h001;
            end
        end
        return res;
    endfunction

    // =========================================================
    // link-side shifter; its frame clear comes from a core flip-flop
    dwc_link_shift u_link (
        .link_clk   (serial_clk),
        .clear_n    (st_reg.clear_n),
        .cs_n       (cs_n),
        .din        (din_dir),
        .shift_word (link_word),
        .bit_count  (link_count)
    );

    // =========================================================
    // next state
    always_comb begin
        logic       cs_rise;
        logic       cs_fall;
        logic       stb_fall;
        logic       serial_mode;
        logic [1:0] cmd;
        logic       cmd_ok;
        logic       do_save;

        st_next     = st_reg;
        cs_rise     = st_reg.cs_s2 && !st_reg.cs_d;
        cs_fall     = !st_reg.cs_s2 && st_reg.cs_d;
        stb_fall    = !st_reg.stb_s2 && st_reg.stb_d;
        serial_mode = st_reg.mode_s2;
        cmd         = 2'h0;
        cmd_ok      = 1'b0;
        do_save     = 1'b0;

        // pins pass two flip-flops before the core logic looks at them; the shifter samples cs_n and din_dir directly
        st_next.cs_s1   = cs_n;
        st_next.cs_s2   = st_reg.cs_s1;
        st_next.cs_d    = st_reg.cs_s2;
        st_next.stb_s1  = serial_clk;
        st_next.stb_s2  = st_reg.stb_s1;
        st_next.stb_d   = st_reg.stb_s2;
        st_next.dir_s1  = din_dir;
        st_next.dir_s2  = st_reg.dir_s1;
        st_next.mode_s1 = iface_mode_strap;
        st_next.mode_s2 = st_reg.mode_s1;

        // release the shifter once chip select is seen low, hold it cleared after a frame
        if (cs_fall) begin
            st_next.clear_n = 1'b1;
        end

        // frame command and length check
        if (link_count == dwc_pkg::LEN_LONG) begin
            cmd    = {link_word[dwc_pkg::LONG_CMD_HI], link_word[dwc_pkg::LONG_CMD_LO]};
            cmd_ok = 1'b1;
        end else if (link_count == dwc_pkg::LEN_SHORT) begin
            cmd    = {link_word[dwc_pkg::SHORT_CMD_HI], link_word[dwc_pkg::SHORT_CMD_LO]};
            cmd_ok = (cmd == dwc_pkg::CMD_SAVE) || (cmd == dwc_pkg::CMD_RESTORE);
        end

        case (st_reg.state)
            dwc_pkg::DWC_BOOT: begin
                st_next.wiper = st_reg.nv;
                st_next.state = dwc_pkg::DWC_IDLE;
            end
            dwc_pkg::DWC_IDLE: begin
                if (!serial_mode) begin
                    if (!st_reg.cs_s2 && stb_fall) begin
                        st_next.wiper = dwc_step(st_reg.wiper, st_reg.dir_s2);
                    end
                    if (cs_rise && st_reg.stb_s2) begin
                        do_save = 1'b1;
                    end
                end else if (cs_rise && cmd_ok) begin
                    case (cmd)
                        dwc_pkg::CMD_WRITE: begin
                            // position from clocks 9 to 18
                            st_next.wiper = link_word[dwc_pkg::LONG_POS_MSB:dwc_pkg::LONG_POS_LSB];
                        end
                        dwc_pkg::CMD_SAVE: begin
                            do_save = 1'b1;
                        end
                        dwc_pkg::CMD_RESTORE: begin
                            st_next.wiper = st_reg.nv;
                        end
                        default: begin
                            st_next.wiper = st_reg.wiper;
                        end
                    endcase
                end
                if (do_save) begin
                    st_next.pending = st_reg.wiper;
                    st_next.timer   = '0;
                    st_next.state   = dwc_pkg::DWC_SAVE;
                end
            end
            dwc_pkg::DWC_SAVE: begin
                // fixed save time, other operations ignored meanwhile
                if (st_reg.timer == SAVE_LAST) begin
                    st_next.nv    = st_reg.pending;
                    st_next.state = dwc_pkg::DWC_IDLE;
                end else begin
                    st_next.timer = st_reg.timer + 22'h000001;
                end
            end
            default: begin
                st_next.state = dwc_pkg::DWC_BOOT;
            end
        endcase

        // frame seen: hold shifter cleared until the next selection
        if (cs_rise) begin
            st_next.clear_n = 1'b0;
        end

        // standby while deselected and not saving
        st_next.standby = st_reg.cs_s2 && (st_next.state == dwc_pkg::DWC_IDLE);
        // busy flag registered with the state so the output comes from a flop
        st_next.busy    = (st_next.state == dwc_pkg::DWC_SAVE);
    end

    // =========================================================
    // registers
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg         <= '0;
            st_reg.state   <= dwc_pkg::DWC_BOOT;
            st_reg.nv      <= dwc_pkg::NV_FACTORY;
            st_reg.cs_s1   <= 1'b1;
            st_reg.cs_s2   <= 1'b1;
            st_reg.cs_d    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // =========================================================
    // outputs straight from flip-flops
    assign wiper_pos = st_reg.wiper;
    assign nv_pos    = st_reg.nv;
    assign nv_busy   = st_reg.busy;
    assign standby   = st_reg.standby;

endmodule

`default_nettype wire

// [dv/dwc_wiper_ctrl_asserts.sv]
// port-level checks of the wiper control
`default_nettype none
module dwc_wiper_ctrl_asserts #(
    parameter int unsigned NV_SAVE_CYCLES = 20
) (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // host pins
    input wire logic       serial_clk,
    input wire logic       cs_n,
    input wire logic       din_dir,
    input wire logic       iface_mode_strap,
    // state and status
    input wire logic [9:0] wiper_pos,
    input wire logic [9:0] nv_pos,
    input wire logic       nv_busy,
    input wire logic       standby
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BUSY_MAX = NV_SAVE_CYCLES + 4;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ====================
    AST_BOOT_LOAD: assert property ($rose(resetn) |->
        nv_pos == dwc_pkg::NV_FACTORY ##[1:3] wiper_pos == nv_pos) else $error("no load at power-up");
    AST_STEP_ONE: assert property (!iface_mode_strap && !$past(iface_mode_strap, 4) &&
        !cs_n && !$past(cs_n, 4) && $changed(wiper_pos) |-> {1'b0, wiper_pos} == ($past(din_dir, 3) ?
        {1'b0, $past(wiper_pos)} + 11'h001 : {1'b0, $past(wiper_pos)} - 11'h001)) else $error("bad step");
    AST_DESEL_HOLD: assert property ((cs_n && !iface_mode_strap)[*6] |-> $stable(wiper_pos))
        else $error("wiper moved while deselected");
    AST_SAVE_START: assert property (!iface_mode_strap && $rose(cs_n) && serial_clk && !nv_busy
        |-> ##[2:6] nv_busy) else $error("no save on deselect");
    AST_SAVE_SKIP: assert property (!iface_mode_strap && $rose(cs_n) && !serial_clk && !nv_busy
        |-> !nv_busy[*6]) else $error("unwanted save");
    AST_SAVE_LEN: assert property ($rose(nv_busy) |-> nv_busy[*8] ##[1:BUSY_MAX] !nv_busy)
        else $error("save time wrong");
    AST_SERIAL_LATCH: assert property (iface_mode_strap && $past(iface_mode_strap, 2) && $changed(wiper_pos)
        |-> cs_n && $past(cs_n, 2)) else $error("wiper moved inside frame");
    AST_STANDBY: assert property ((cs_n && !nv_busy)[*8] |-> standby)
        else $error("idle without standby");
endmodule
bind dwc_wiper_ctrl dwc_wiper_ctrl_asserts #(.NV_SAVE_CYCLES(NV_SAVE_CYCLES)) i_asserts (
    .core_clk(core_clk), .resetn(resetn), .serial_clk(serial_clk), .cs_n(cs_n), .din_dir(din_dir),
    .iface_mode_strap(iface_mode_strap), .wiper_pos(wiper_pos), .nv_pos(nv_pos), .nv_busy(nv_busy),
    .standby(standby));
`default_nettype wire

// [dv/dwc_host_model.sv]
// host driving chip select, shift clock or step strobe, and data
`default_nettype none
module dwc_host_model (
    // pacing clock
    input  wire logic core_clk,
    // host pins
    output var logic  serial_clk,
    output var logic  cs_n,
    output var logic  din_dir
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_clk = 1'b0;
        cs_n = 1'b1;
        din_dir = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // msb first, 15 ns clock only inside the frame
    task automatic frame(input logic [23:0] w, input logic is_long);
        cs_n = 1'b0;
        idle(5);
        for (int i = 0; i < (is_long ? 24 : 8); i++) begin
            din_dir = w[23 - i];
            #3.75 serial_clk = 1'b1;
            #7.5 serial_clk = 1'b0;
            #3.75;
        end
        // data no longer held: show the inverse
        din_dir = ~din_dir;
        idle(1);
        cs_n = 1'b1;
        idle(12);
    endtask
    task automatic select();
        cs_n = 1'b0;
        idle(6);
    endtask
    // strobe held at least 4 core cycles each level so the synchroniser sees it
    task automatic step(input logic up);
        din_dir = up;
        idle(4);
        serial_clk = 1'b1;
        idle(4);
        serial_clk = 1'b0;
        idle(6);
    endtask
    // strobe level at deselect picks store or not
    task automatic deselect(input logic store);
        serial_clk = store;
        idle(4);
        cs_n = 1'b1;
        idle(8);
        serial_clk = 1'b0;
        din_dir = ~din_dir;
        idle(4);
    endtask
endmodule
`default_nettype wire

// [dv/dwc_wiper_ctrl_tb_top.sv]
// self-checking bench of the wiper control
`default_nettype none
module dwc_wiper_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned SAVE_CYC = 20;
    logic       core_clk;
    logic       resetn;
    logic       iface_mode_strap;
    logic       serial_clk;
    logic       cs_n;
    logic       din_dir;
    logic [9:0] wiper_pos;
    logic [9:0] nv_pos;
    logic       nv_busy;
    logic       standby;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cycles = 0;
    dwc_host_model i_host (.core_clk(core_clk), .serial_clk(serial_clk), .cs_n(cs_n), .din_dir(din_dir));
    dwc_wiper_ctrl #(.NV_SAVE_CYCLES(SAVE_CYC)) i_dut (.core_clk(core_clk), .resetn(resetn),
        .serial_clk(serial_clk), .cs_n(cs_n), .din_dir(din_dir), .iface_mode_strap(iface_mode_strap),
        .wiper_pos(wiper_pos), .nv_pos(nv_pos), .nv_busy(nv_busy), .standby(standby));
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ceiling far above the fewer than one thousand cycles the tests need
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic wait_save(input logic [9:0] exp);
        int k;
        k = 0;
        while (nv_busy !== 1'b0 && k < SAVE_CYC + 10) begin
            @(negedge core_clk);
            k++;
        end
        check("busy", {9'h000, nv_busy}, 10'h000);
        check("nv", nv_pos, exp);
    endtask
    task automatic power_up();
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        repeat (12) @(negedge core_clk);
        check("nv", nv_pos, dwc_pkg::NV_FACTORY);
        check("wiper", wiper_pos, dwc_pkg::NV_FACTORY);
        check("standby", {9'h000, standby}, 10'h001);
        $display("test power_up done");
    endtask
    initial begin
        iface_mode_strap = 1'b1;
        power_up();
        i_host.frame({2'b00, dwc_pkg::CMD_WRITE, 4'h0, 10'h3FE, 6'h00}, 1'b1);
        check("wiper", wiper_pos, 10'h3FE);
        i_host.frame({2'b00, dwc_pkg::CMD_WRITE, 4'h0, 10'h155, 6'h00}, 1'b0);
        check("wiper", wiper_pos, 10'h3FE);
        $display("test serial_write done");
        iface_mode_strap = 1'b0;
        i_host.select();
        i_host.step(1'b1);
        check("wiper", wiper_pos, 10'h3FF);
        i_host.step(1'b1);
        check("wiper", wiper_pos, 10'h3FF);
        i_host.deselect(1'b0);
        check("nv", nv_pos, dwc_pkg::NV_FACTORY);
        i_host.step(1'b0);
        check("wiper", wiper_pos, 10'h3FF);
        i_host.select();
        i_host.step(1'b0);
        check("wiper", wiper_pos, 10'h3FE);
        i_host.deselect(1'b1);
        wait_save(10'h3FE);
        $display("test up_down done");
        iface_mode_strap = 1'b1;
        i_host.idle(6);
        i_host.frame({2'b00, dwc_pkg::CMD_WRITE, 4'h0, 10'h001, 6'h00}, 1'b1);
        i_host.frame({2'b00, dwc_pkg::CMD_SAVE, 20'h00000}, 1'b0);
        wait_save(10'h001);
        for (int i = 0; i < 2; i++) begin
            i_host.frame({2'b00, dwc_pkg::CMD_WRITE, 4'h0, 10'h155, 6'h00}, 1'b1);
            i_host.frame({2'b00, dwc_pkg::CMD_RESTORE, 20'hFFFFF}, i[0]);
            check("wiper", wiper_pos, 10'h001);
        end
        $display("test serial_copy done");
        power_up();
        stop_test();
    end
endmodule
`default_nettype wire
